// ### pkg/hscp_pkg.sv
/*
  hscp_pkg: constants and types of the host serial control port.
  Assumes one clock domain at 125 MHz; all pin levels are synchronised
  inside the block before use, except RST, which also clears the flops directly.
*/
package hscp_pkg;

  // host interface chosen by the reset-time straps
  typedef enum logic [2:0] {
    MD_NONE,                               // no host, monitor-channel slave
    MD_SERIAL,                             // four-wire serial control port
    MD_PAR_STROBE,                         // parallel, data strobe style
    MD_PAR_NONMUX,                         // parallel, separate address bus
    MD_PAR_MUX                             // parallel, multiplexed address/data
  } hscp_mode_t;

  // position inside one serial access
  typedef enum logic [2:0] {
    PH_IDLE,                               // chip select high
    PH_HDR,                                // waiting for the header byte
    PH_ADDR,                               // next byte is an address
    PH_DATA,                               // next byte is a data slot
    PH_DROP                                // unknown header, rest ignored
  } hscp_phase_t;

  // programming sequence family picked by the header
  typedef enum logic [1:0] {
    SQ_ALT,                                // address/data alternating
    SQ_CONST,                              // one address, data forever
    SQ_RDWR                                // reads, then write-only run
  } hscp_seq_t;

  localparam int          BYTE_BITS     = 8;
  localparam logic [2:0]  BIT_LAST      = 3'h7;
  localparam logic [3:0]  TX_SHIFTS     = 4'h7;
  localparam logic [7:0]  HDR_ALT_NI    = 8'h40;
  localparam logic [7:0]  HDR_ALT_IL    = 8'h48;
  localparam logic [7:0]  HDR_CONST     = 8'h43;
  localparam logic [7:0]  HDR_RW_NI     = 8'h41;
  localparam logic [7:0]  HDR_RW_IL     = 8'h49;
  localparam int          HDR_HALF_BIT  = 2;
  localparam logic [7:0]  HDR_HALF_MASK = 8'h04;
  localparam int          ADDR_RD_BIT   = 7;
  localparam logic [7:0]  FIFO_TOP      = 8'h1f;
  localparam logic [7:0]  FIFO_ALT_A    = 8'h6a;
  localparam logic [7:0]  FIFO_ALT_B    = 8'h7a;
  localparam int          FIFO_PTR_W    = 6;

endpackage

// ### hw/hscp_top.sv
/*
  hscp_top: host access front end. Picks the host interface from the
  straps seen while RST is high, runs the serial control port (header,
  address and data bytes over SCL/SERIAL_IN_LINE/SERIAL_OUT_LINE/CS_N) and drives the interrupt
  pin. Assumes an internal register file on CLK that answers REG_RD with
  REG_RDATA valid in the following cycle, and that SCL stays high and low
  for at least five CLK periods each.
*/
// Operation
// - straps are captured only while reset is high
// - strap levels decode to parallel, serial or none
// - with parallel straps, an ALE edge after reset selects multiplexed bus
// - interrupt pin low active, reprogrammable high active
// - four lines, data moves at serial clock rate
// - chip select falling edge starts an access
// - sample on SCL rise, shift out on fall
// - bytes of eight bits, most significant first
// - first byte is a header choosing the sequence
// - header bit two selects upper address half
// - header 40 alternates address and data slots
// - header 48 returns read data under next address
// - header 43 keeps one address for all data
// - with header 43, FIFO addresses use a per-byte incrementing pointer
// - header 41 reads then write-only run, non-interleaved
// - header 49 is the interleaved read-then-write form
// - write address ends reads, then data written repeatedly
`timescale 1ns/10ps
module hscp_top
  import hscp_pkg::*;
#(
  parameter int PTR_W = FIFO_PTR_W         // FIFO pointer width
) (
  input  wire logic             CLK,       // 125 MHz system clock
  input  wire logic             RST,       // async reset, active high
  input  wire logic             WR_PIN,    // write strobe / read-write strap
  input  wire logic             RD_PIN,    // read strobe / data_strobe strap
  input  wire logic             ALE_PIN,   // address latch strap
  input  wire logic             CS_N,      // chip select, also strap
  input  wire logic             SCL,       // serial clock from the host
  input  wire logic             SERIAL_IN_LINE,       // serial_in_line
  output logic                  SDX_O,     // serial_out_line level
  output logic                  SDX_OE_N,  // serial_out_line drive, low = on
  input  wire logic             IRQ_REQ,   // interrupt pending, internal
  input  wire logic             IRQ_HIGH,  // interrupt polarity high active
  output logic                  INT_O,     // interrupt pin level
  output logic                  INT_OE_N,  // interrupt pin drive, low = on
  output hscp_mode_t            HOST_MODE, // selected host interface
  output logic [7:0]            REG_ADDR,  // register address
  output logic [7:0]            REG_WDATA, // register write data
  output logic                  REG_WR,    // one-cycle write strobe
  output logic                  REG_RD,    // one-cycle read strobe
  input  wire logic [7:0]       REG_RDATA, // read data, cycle after REG_RD
  output logic                  FIFO_SEL,  // access targets the FIFO
  output logic [PTR_W-1:0]      FIFO_PTR   // FIFO slot of the strobe
);

  // FIFO window decode, used for both directions
  function automatic logic is_fifo(input logic [7:0] a);
    is_fifo = (a <= FIFO_TOP) || (a == FIFO_ALT_A) || (a == FIFO_ALT_B);
  endfunction

  // pin synchronisers: first stage read only by the second
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic       scl_s3;
  logic       cs_s3;
  logic       ale_s3;
  logic       rst_s1;
  logic       rst_s2;

  always_ff @(posedge CLK) begin
    pin_s1 <= {SCL, SERIAL_IN_LINE, CS_N, WR_PIN, RD_PIN, ALE_PIN};
    pin_s2 <= pin_s1;
    scl_s3 <= pin_s2[5];
    cs_s3  <= pin_s2[3];
    ale_s3 <= pin_s2[0];
    rst_s1 <= RST;
    rst_s2 <= rst_s1;
  end

  wire scl_s2 = pin_s2[5];
  wire sdr_s2 = pin_s2[4];
  wire cs_s2  = pin_s2[3];
  wire wr_s2  = pin_s2[2];
  wire rd_s2  = pin_s2[1];
  wire ale_s2 = pin_s2[0];

  // straps: no async reset, they must keep loading while RST is high
  logic       strap_wr_q;
  logic       strap_rd_q;
  logic       strap_cs_q;
  logic       strap_ale_q;
  logic       mux_seen_q;
  hscp_mode_t mode_q;

  always_ff @(posedge CLK) begin
    if (rst_s2) begin
      strap_wr_q  <= wr_s2;
      strap_rd_q  <= rd_s2;
      strap_cs_q  <= cs_s2;
      strap_ale_q <= ale_s2;
    end
  end

  // an ALE edge sticks until reset; cleared all through reset so power-up with reset high clears
  wire ale_edge = ale_s2 ^ ale_s3;

  always_ff @(posedge CLK) begin
    if (rst_s2) begin
      mux_seen_q <= 1'b0;
    end else begin
      mux_seen_q <= mux_seen_q | ale_edge;
    end
  end

  // strap decode; unlisted combinations fall back to no host
  wire par_sel = strap_wr_q & strap_rd_q & strap_cs_q;
  wire ser_sel = ~strap_wr_q & ~strap_rd_q & strap_cs_q & ~strap_ale_q;
  hscp_mode_t mode_d;
  assign mode_d = !par_sel ? (ser_sel ? MD_SERIAL : MD_NONE) :
                  mux_seen_q  ? MD_PAR_MUX :
                  strap_ale_q ? MD_PAR_STROBE : MD_PAR_NONMUX;

  always_ff @(posedge CLK) begin
    mode_q <= mode_d;
  end

  // serial edge events; clock ignored while deselected
  wire serial_on = (mode_q == MD_SERIAL);
  wire cs_fall   = serial_on & ~cs_s2 & cs_s3;
  wire scl_rise  = serial_on & ~cs_s2 & scl_s2 & ~scl_s3;
  wire scl_fall  = serial_on & ~cs_s2 & ~scl_s2 & scl_s3;

  hscp_phase_t     phase_q;
  hscp_seq_t       seq_q;
  logic            intl_q;
  logic            half_q;
  logic            isrd_q;
  logic            fifo_q;
  logic [2:0]      bit_cnt_q;
  logic [6:0]      rx_sh_q;
  logic [PTR_W-1:0] ptr_q;

  // byte assembly, MSB first
  wire [7:0] rx_byte   = {rx_sh_q, sdr_s2};
  wire       byte_done = scl_rise & (bit_cnt_q == BIT_LAST) & (phase_q != PH_IDLE);

  // header decode with the half-select bit masked off
  wire [7:0] hdr_base  = rx_byte & ~HDR_HALF_MASK;
  wire hdr_alt   = (hdr_base == HDR_ALT_NI) | (hdr_base == HDR_ALT_IL);
  wire hdr_const = (hdr_base == HDR_CONST);
  wire hdr_rw    = (hdr_base == HDR_RW_NI) | (hdr_base == HDR_RW_IL);
  wire hdr_il    = (hdr_base == HDR_ALT_IL) | (hdr_base == HDR_RW_IL);
  wire hdr_ok    = hdr_alt | hdr_const | hdr_rw;
  hscp_seq_t hdr_seq;
  assign hdr_seq = hdr_const ? SQ_CONST : (hdr_rw ? SQ_RDWR : SQ_ALT);

  // byte-level actions
  wire       got_hdr  = byte_done & (phase_q == PH_HDR);
  wire       got_addr = byte_done & (phase_q == PH_ADDR);
  wire       got_data = byte_done & (phase_q == PH_DATA);
  wire       ab_rd    = rx_byte[ADDR_RD_BIT];
  wire [7:0] ab_addr  = {half_q, rx_byte[6:0]};
  wire       const_q  = (seq_q == SQ_CONST);
  wire       do_rd    = (got_addr & ab_rd) | (got_data & const_q & isrd_q);
  wire       do_wr    = got_data & ~isrd_q;
  // interleaved reads take the next slot as an address again
  wire       addr_stay = ab_rd & intl_q & ~const_q;
  // constant address and the write run of 41/49 never leave data slots
  wire       data_stay = const_q | ((seq_q == SQ_RDWR) & ~isrd_q);
  wire       ptr_step  = got_data & const_q & fifo_q;
  wire [PTR_W-1:0] ptr_inc = ptr_q + {{(PTR_W-1){1'b0}}, 1'b1};

  // bit counter restarted on every select; receive shifter only shifts
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bit_cnt_q <= 3'h0;
      rx_sh_q   <= 7'h00;
    end else if (cs_fall) begin
      bit_cnt_q <= 3'h0;
    end else if (scl_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      rx_sh_q   <= rx_byte[6:0];
    end
  end

  // access sequencing
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      phase_q <= PH_IDLE;
    end else if (!serial_on || cs_s2) begin
      phase_q <= PH_IDLE;
    end else if (cs_fall) begin
      phase_q <= PH_HDR;
    end else if (got_hdr) begin
      phase_q <= hdr_ok ? PH_ADDR : PH_DROP;
    end else if (got_addr) begin
      phase_q <= addr_stay ? PH_ADDR : PH_DATA;
    end else if (got_data) begin
      phase_q <= data_stay ? PH_DATA : PH_ADDR;
    end
  end

  // header attributes and the current address kind
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      seq_q  <= SQ_ALT;
      intl_q <= 1'b0;
      half_q <= 1'b0;
      isrd_q <= 1'b0;
      fifo_q <= 1'b0;
    end else if (got_hdr) begin
      seq_q  <= hdr_seq;
      intl_q <= hdr_il;
      half_q <= rx_byte[HDR_HALF_BIT];
    end else if (got_addr) begin
      isrd_q <= ab_rd;
      fifo_q <= const_q & is_fifo(ab_addr);
    end
  end

  // FIFO pointer: zero at the address, one step per data byte
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ptr_q <= '0;
    end else if (got_addr) begin
      ptr_q <= '0;
    end else if (ptr_step) begin
      ptr_q <= ptr_inc;
    end
  end

  // register strobes toward the internal register file
  logic [7:0]       reg_addr_q;
  logic [7:0]       reg_wdata_q;
  logic             reg_wr_q;
  logic             reg_rd_q;
  logic             fifo_sel_q;
  logic [PTR_W-1:0] fifo_ptr_q;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
    end else begin
      reg_wr_q <= do_wr & (phase_q != PH_DROP);
      reg_rd_q <= do_rd;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      reg_addr_q  <= 8'h00;
      reg_wdata_q <= 8'h00;
      fifo_sel_q  <= 1'b0;
      fifo_ptr_q  <= '0;
    end else begin
      if (got_addr) begin
        reg_addr_q <= ab_addr;
        fifo_sel_q <= const_q & is_fifo(ab_addr);
        fifo_ptr_q <= '0;
      end else if (do_rd || do_wr) begin
        fifo_ptr_q <= (do_rd && fifo_q) ? ptr_inc : ptr_q;
      end
      if (do_wr) begin
        reg_wdata_q <= rx_byte;
      end
    end
  end

  // transmit path: read data loaded after the strobe, sent on falls
  logic       rd_pend_q;
  logic       tx_rdy_q;
  logic [7:0] tx_buf_q;
  logic [6:0] tx_sh_q;
  logic [3:0] tx_left_q;
  logic       sdx_q;
  logic       sdx_oe_n_q;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rd_pend_q <= 1'b0;
      tx_rdy_q  <= 1'b0;
      tx_buf_q  <= 8'h00;
    end else begin
      rd_pend_q <= reg_rd_q;
      if (cs_s2 || (scl_fall && tx_rdy_q)) begin
        tx_rdy_q <= 1'b0;
      end
      if (rd_pend_q && !cs_s2) begin
        tx_rdy_q <= 1'b1;                  // later than the clear: new data wins
        tx_buf_q <= REG_RDATA;
      end
    end
  end

  // line released between read bytes so 40 can share one wire
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_sh_q    <= 7'h00;
      tx_left_q  <= 4'h0;
      sdx_q      <= 1'b0;
      sdx_oe_n_q <= 1'b1;
    end else if (cs_s2 || !serial_on) begin
      tx_left_q  <= 4'h0;
      sdx_oe_n_q <= 1'b1;
    end else if (scl_fall) begin
      if (tx_rdy_q) begin
        sdx_q      <= tx_buf_q[7];
        tx_sh_q    <= tx_buf_q[6:0];
        tx_left_q  <= TX_SHIFTS;
        sdx_oe_n_q <= 1'b0;
      end else if (tx_left_q != 4'h0) begin
        sdx_q     <= tx_sh_q[6];
        tx_sh_q   <= {tx_sh_q[5:0], 1'b0};
        tx_left_q <= tx_left_q - 4'h1;
      end else begin
        sdx_oe_n_q <= 1'b1;
      end
    end
  end

  // interrupt pin: open drain low active, push-pull when high active
  logic int_q;
  logic int_oe_n_q;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      int_q      <= 1'b0;
      int_oe_n_q <= 1'b1;
    end else begin
      int_q      <= IRQ_HIGH & IRQ_REQ;
      int_oe_n_q <= ~IRQ_HIGH & ~IRQ_REQ;
    end
  end

  assign SDX_O     = sdx_q;
  assign SDX_OE_N  = sdx_oe_n_q;
  assign INT_O     = int_q;
  assign INT_OE_N  = int_oe_n_q;
  assign HOST_MODE = mode_q;
  assign REG_ADDR  = reg_addr_q;
  assign REG_WDATA = reg_wdata_q;
  assign REG_WR    = reg_wr_q;
  assign REG_RD    = reg_rd_q;
  assign FIFO_SEL  = fifo_sel_q;
  assign FIFO_PTR  = fifo_ptr_q;

endmodule // hscp_top

// ### test/hscp_top_properties.sv
/*
  hscp_top_properties: port checker of hscp_top.
  Assumes one clock domain and attachment by the bind at the foot.
*/
`timescale 1ns/10ps
module hscp_top_properties
  import hscp_pkg::*;
(
  input wire logic       CLK,      // system clock
  input wire logic       RST,      // async reset
  input wire logic       CS_N,     // chip select
  input wire logic       SCL,      // serial clock
  input wire logic       IRQ_REQ,  // interrupt pending
  input wire logic       IRQ_HIGH, // interrupt polarity
  input wire logic       INT_O,    // interrupt pin level
  input wire logic       INT_OE_N, // interrupt pin drive
  input wire logic       SDX_O,    // serial_out_line level
  input wire logic       SDX_OE_N, // serial_out_line drive
  input wire logic       REG_WR,   // write strobe
  input wire logic       REG_RD,   // read strobe
  input wire hscp_mode_t HOST_MODE // chosen host interface
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // deselected long enough that no byte can still be finishing
  sequence s_idle;
    CS_N [*8];
  endsequence
  // strap capture is over well before six edges past release
  sequence s_mode_moves;
    !RST [*6] ##1 $changed(HOST_MODE);
  endsequence
  a_idle_no_strobe: assert property (s_idle |-> !REG_WR && !REG_RD)
    else $error("strobe while deselected");
  a_idle_released: assert property (s_idle |-> SDX_OE_N)
    else $error("serial out driven while deselected");
  a_wr_single: assert property (REG_WR |=> !REG_WR)
    else $error("write strobe longer than one cycle");
  a_rd_single: assert property (REG_RD |=> !REG_RD)
    else $error("read strobe longer than one cycle");
  a_strobe_excl: assert property (!(REG_WR && REG_RD))
    else $error("read and write strobe together");
  a_int_high: assert property (IRQ_HIGH && IRQ_REQ |=> INT_O && !INT_OE_N)
    else $error("high active interrupt not driven high");
  a_int_low: assert property (!IRQ_HIGH && IRQ_REQ |=> !INT_O && !INT_OE_N)
    else $error("low active interrupt not pulled low");
  a_int_quiet: assert property (!IRQ_HIGH && !IRQ_REQ |=> INT_OE_N)
    else $error("idle open drain interrupt still driven");
  a_shift_on_fall: assert property (!SDX_OE_N && $changed(SDX_O) |-> !SCL && !$past(SCL, 2))
    else $error("serial out changed outside a clock fall");
  a_mode_fixed: assert property (s_mode_moves |-> HOST_MODE == MD_PAR_MUX)
    else $error("host mode changed after reset");
endmodule // hscp_top_properties

bind hscp_top hscp_top_properties chk_u (.CLK(CLK), .RST(RST), .CS_N(CS_N), .SCL(SCL),
  .IRQ_REQ(IRQ_REQ), .IRQ_HIGH(IRQ_HIGH), .INT_O(INT_O), .INT_OE_N(INT_OE_N), .SDX_O(SDX_O),
  .SDX_OE_N(SDX_OE_N), .REG_WR(REG_WR), .REG_RD(REG_RD), .HOST_MODE(HOST_MODE));

// ### test/hscp_host_model.sv
/*
  hscp_host_model: serial clock master of the control port.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/10ps
module hscp_host_model (
  output logic      scl,     // serial clock, stands high between frames
  output logic      serial_in_line,     // serial_in_line toward the device
  output logic      cs_n,    // chip select, active low
  input  wire logic serial_out_line,     // serial_out_line level
  input  wire logic sdx_oe_n // device drive, low = on
);
  logic last_q; // last level seen on serial_out_line
  initial begin
    scl = 1'b1;
    serial_in_line = 1'b0;
    cs_n = 1'b1;
    last_q = 1'b0;
  end
  // a released line reads as the inverse of its last level, never a kind guess
  function automatic logic line_level();
    return sdx_oe_n ? ~last_q : serial_out_line;
  endfunction
  task automatic select();
    cs_n = 1'b0;
    #100;
  endtask
  // one byte, msb first; drive on the fall, sample on the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      #62.5 scl = 1'b0;
      serial_in_line = tx[i];
      #62.5 scl = 1'b1;
      last_q = line_level();
      rx[i] = last_q;
    end
  endtask
  task automatic deselect();
    #100 cs_n = 1'b1;
    serial_in_line = ~serial_in_line; // data line toggled between frames so a stale level is never relied on
    #200;
  endtask
endmodule // hscp_host_model

// ### test/hscp_top_bench.sv
/*
  hscp_top_bench: self-checking bench of hscp_top.
  Assumes the host model drives the serial pins and the bench the rest.
*/
`timescale 1ns/10ps
module hscp_top_bench
  import hscp_pkg::*;
;
  typedef struct packed {logic [7:0] hdr, a, d, exp_a; logic [1:0] kind;} hscp_row_t;
  logic       CLK, RST, WR_PIN, RD_PIN, ALE_PIN, strap_cs_low, IRQ_REQ, IRQ_HIGH;
  logic [7:0] REG_RDATA = 8'h00;
  logic [7:0] rx;
  wire        SCL, SERIAL_IN_LINE, host_cs_n, SDX_O, SDX_OE_N, INT_O, INT_OE_N, REG_WR, REG_RD, FIFO_SEL;
  wire [7:0]  REG_ADDR, REG_WDATA;
  wire [5:0]  FIFO_PTR;
  hscp_mode_t HOST_MODE;
  wire        CS_N = host_cs_n & ~strap_cs_low; // strap pulls chip select low
  int         bad_count = 0;
  int         comparisons = 0;
  logic [23:0] evq[$];
  // kind 1 write, 2 read, 0 no strobe at all
  localparam hscp_row_t ROWS [6] = '{'{8'h40, 8'h05, 8'hab, 8'h05, 2'h1},
    '{8'h44, 8'h05, 8'hab, 8'h85, 2'h1}, '{8'h40, 8'h85, 8'h00, 8'h05, 2'h2},
    '{8'h4c, 8'h91, 8'h00, 8'h91, 2'h2}, '{8'h48, 8'h12, 8'h34, 8'h12, 2'h1},
    '{8'h55, 8'h05, 8'hab, 8'h05, 2'h0}};
  localparam logic [3:0] STRAPS [4] = '{4'he, 4'hc, 4'h1, 4'h0};
  localparam hscp_mode_t MODES [4] = '{MD_PAR_STROBE, MD_PAR_NONMUX, MD_NONE, MD_SERIAL};
  localparam logic [7:0] CADDR [3] = '{8'h1f, 8'h6a, 8'h7a};

  hscp_host_model host_u (.scl(SCL), .serial_in_line(SERIAL_IN_LINE), .cs_n(host_cs_n), .serial_out_line(SDX_O),
    .sdx_oe_n(SDX_OE_N));
  hscp_top dut_u (.CLK(CLK), .RST(RST), .WR_PIN(WR_PIN), .RD_PIN(RD_PIN), .ALE_PIN(ALE_PIN),
    .CS_N(CS_N), .SCL(SCL), .SERIAL_IN_LINE(SERIAL_IN_LINE), .SDX_O(SDX_O), .SDX_OE_N(SDX_OE_N), .IRQ_REQ(IRQ_REQ),
    .IRQ_HIGH(IRQ_HIGH), .INT_O(INT_O), .INT_OE_N(INT_OE_N), .HOST_MODE(HOST_MODE),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .FIFO_SEL(FIFO_SEL), .FIFO_PTR(FIFO_PTR));

  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // register file stand-in answers with a code of the address; every strobe is logged
  always @(posedge CLK) begin
    if (REG_RD === 1'b1) REG_RDATA <= REG_ADDR ^ 8'h5a;
    if (REG_WR === 1'b1 || REG_RD === 1'b1)
      evq.push_back({REG_RD, FIFO_SEL, FIFO_PTR, REG_ADDR, REG_WDATA});
  end

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_mode(input hscp_mode_t exp);
    comparisons++;
    if (HOST_MODE !== exp) begin
      bad_count++;
      $display("wrong value host mode expected %0d seen %0d", exp, HOST_MODE);
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // pop one logged strobe; a missing one reads as unknown and fails
  task automatic expect_ev(input logic rd, input logic sel, input logic [5:0] ptr,
                           input logic [7:0] a, input logic [7:0] d);
    logic [23:0] e;
    e = evq.size() > 0 ? evq.pop_front() : 24'hxxxxxx;
    check_byte("strobe kind", {7'h0, rd}, {7'h0, e[23]});
    check_byte("address", a, e[15:8]);
    if (!rd) check_byte("write data", d, e[7:0]);
    check_byte("fifo slot", {1'b0, sel, ptr}, {1'b0, e[22:16]});
  endtask
  // straps held valid for the whole reset and kept afterwards
  task automatic strap_reset(input logic [3:0] s);
    RST <= 1'b1;
    {WR_PIN, RD_PIN, ALE_PIN, strap_cs_low} <= s;
    repeat (12) @(posedge CLK);
    check_byte("reset outputs", 8'h06, {5'h0, SDX_OE_N, INT_OE_N, INT_O});
    RST <= 1'b0;
    repeat (6) @(posedge CLK);
  endtask
  // rx keeps what came back during the third byte
  task automatic access(input logic [7:0] b[]);
    logic [7:0] r;
    host_u.select();
    foreach (b[i]) begin
      host_u.xfer(b[i], r);
      if (i == 2) rx = r;
    end
    host_u.deselect();
  endtask

  initial begin
    #300000;
    bad_count++;
    print_verdict();
  end
  initial begin
    {RST, WR_PIN, RD_PIN, ALE_PIN, strap_cs_low, IRQ_REQ, IRQ_HIGH} = 7'h40;
    @(posedge CLK);
    foreach (STRAPS[k]) begin
      strap_reset(STRAPS[k]);
      check_mode(MODES[k]);
      if (k == 1) begin
        ALE_PIN <= 1'b1;
        repeat (8) @(posedge CLK);
        check_mode(MD_PAR_MUX);
      end
    end
    for (int m = 0; m < 4; m++) begin
      {IRQ_HIGH, IRQ_REQ} <= 2'(m);
      repeat (3) @(posedge CLK);
      @(negedge CLK);
      check_byte("interrupt pin", {6'h0, m[1] & m[0], ~(m[1] | m[0])}, {6'h0, INT_O, INT_OE_N});
      @(posedge CLK);
    end
    foreach (ROWS[k]) begin
      access('{ROWS[k].hdr, ROWS[k].a, ROWS[k].d});
      if (ROWS[k].kind != 2'h0)
        expect_ev(ROWS[k].kind[1], 1'b0, 6'h0, ROWS[k].exp_a, ROWS[k].d);
      if (ROWS[k].kind == 2'h2)
        check_byte("read back", ROWS[k].exp_a ^ 8'h5a, rx);
      check_byte("strobe count", 8'h0, 8'(evq.size()));
    end
    // fifo run: one address, the pointer walks with each data byte
    foreach (CADDR[k]) begin
      access('{HDR_CONST, CADDR[k], 8'h10, 8'h11, 8'h12});
      for (int j = 0; j < 3; j++)
        expect_ev(1'b0, 1'b1, 6'(j), CADDR[k], 8'h10 + 8'(j));
    end
    // reads, then a write address ends them and opens a write run
    access('{HDR_RW_NI, 8'h85, 8'h00, 8'h07, 8'h31, 8'h32});
    expect_ev(1'b1, 1'b0, 6'h0, 8'h05, 8'h00);
    check_byte("read back", 8'h05 ^ 8'h5a, rx);
    expect_ev(1'b0, 1'b0, 6'h0, 8'h07, 8'h31);
    expect_ev(1'b0, 1'b0, 6'h0, 8'h07, 8'h32);
    access('{HDR_RW_IL, 8'h83, 8'h06, 8'h33, 8'h44});
    expect_ev(1'b1, 1'b0, 6'h0, 8'h03, 8'h00);
    check_byte("read back", 8'h03 ^ 8'h5a, rx);
    expect_ev(1'b0, 1'b0, 6'h0, 8'h06, 8'h33);
    expect_ev(1'b0, 1'b0, 6'h0, 8'h06, 8'h44);
    // fifo reads: one strobe at the address, then one per data slot
    access('{HDR_CONST, 8'h9f, 8'h00, 8'h00});
    for (int j = 0; j < 3; j++)
      expect_ev(1'b1, 1'b1, 6'(j), 8'h1f, 8'h00);
    check_byte("read back", 8'h1f ^ 8'h5a, rx);
    // clocks while deselected and a cut frame must leave nothing behind
    host_u.xfer(8'hc5, rx);
    access('{HDR_ALT_NI, 8'h05});
    access('{HDR_ALT_NI, 8'h09, 8'h5c});
    expect_ev(1'b0, 1'b0, 6'h0, 8'h09, 8'h5c);
    check_byte("strobe count", 8'h0, 8'(evq.size()));
    print_verdict();
  end
endmodule // hscp_top_bench
